// >>> hdl/sdr_pkg.sv
package sdr_pkg;
  // power-up delay and fail-safe monitor delay, in microseconds
  localparam int unsigned POWERUP_DELAY_US    = 64;
  localparam int unsigned FAILSAFE_DELAY_US   = 2;
  localparam int unsigned CLK_MHZ             = 50;
  localparam int unsigned POWERUP_DELAY_CYC   = POWERUP_DELAY_US * CLK_MHZ;
  localparam int unsigned FAILSAFE_DELAY_CYC  = FAILSAFE_DELAY_US * CLK_MHZ;
  // oscillator start-up timer length, in oscillator cycles
  localparam int unsigned OSC_STARTUP_CYC     = 1024;
  localparam int unsigned RESET_PULSE_CYC     = 4;
  localparam int unsigned CNT_W               = 16;
  // oscillator control register: locked flag position
  localparam int unsigned OSC_CTRL_LOCK_BIT   = 5;
  // reset control register: dip flag position, reset value
  localparam int unsigned RST_CTRL_DIP_BIT    = 1;
  localparam logic [15:0] RST_CTRL_RESET_VAL  = 16'h0000;
  // osc select codes: frc or primary oscillator, each with or without the pll
  localparam logic [2:0]  OSC_SEL_FRC         = 3'h0;
  localparam logic [2:0]  OSC_SEL_FRC_PLL     = 3'h1;
  localparam logic [2:0]  OSC_SEL_PRI         = 3'h2;
  localparam logic [2:0]  OSC_SEL_PRI_PLL     = 3'h3;
  // primary oscillator mode: 2'h3 means disabled
  localparam logic [1:0]  PRI_MODE_OFF        = 2'h3;
  localparam logic [1:0]  PRI_MODE_EC         = 2'h0;

  typedef struct packed {
    logic [2:0] osc_select_cfg;
    logic [1:0] primary_osc_mode_cfg;
    logic       powerup_timer_zero;
  } sdr_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PULSE = 3'b001,
    ST_WAIT  = 3'b010,
    ST_RUN   = 3'b011
  } sdr_state_t;
endpackage

// >>> hdl/sdr_sequencer.sv
`timescale 1ns/1ns
// Function
// R1: dip pulses a whole-device reset
// R2: clock source and pll use chosen from select alone
// R3: oscillator mode runs start-up timer, clock gated
// R4: pll in use holds clock until lock
// R5: power-up delay applied alongside clock hold
// R6: zero delay with crystal uses fail-safe delay
// R7: dip sets reset control flag bit 1
// R8: detection stays active in sleep and idle
// R9: release needs delay done and clock ready
// R10: flag held until software writes zero
module sdr_sequencer (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              supply_dip_reset,
  input  wire logic              sleep_mode,
  input  wire logic              idle_mode,
  input  wire sdr_pkg::sdr_cfg_t cfg,
  input  wire logic              osc_tick,
  input  wire logic [15:0]       osc_control_reg,
  input  wire logic              flag_clear,
  output logic                   device_reset_pulse,
  output logic                   internal_reset,
  output logic                   sysclk_enable,
  output logic [2:0]             clk_source,
  output logic                   pll_in_use,
  output logic [15:0]            reset_control_reg
);
  sdr_pkg::sdr_state_t       state_reg;
  logic                      dip_s1_reg;
  logic                      dip_s2_reg;
  logic                      lock_s1_reg;
  logic                      lock_s2_reg;
  logic [sdr_pkg::CNT_W-1:0] pulse_cnt_reg;
  logic [sdr_pkg::CNT_W-1:0] ost_cnt_reg;
  logic [sdr_pkg::CNT_W-1:0] dly_cnt_reg;
  logic                      osc_mode_reg;
  logic                      ost_done;
  logic                      clk_ready;
  logic                      dly_done;
  logic                      use_pri;
  logic                      use_pll;
  logic                      use_xtal;

  // the dip and lock come from analog sides, synchronise them first
  always_ff @(posedge clk)
  begin
    dip_s1_reg  <= supply_dip_reset;
    dip_s2_reg  <= dip_s1_reg;
    lock_s1_reg <= osc_control_reg[sdr_pkg::OSC_CTRL_LOCK_BIT];
    lock_s2_reg <= lock_s1_reg;
  end

  assign use_pri  = (cfg.osc_select_cfg == sdr_pkg::OSC_SEL_PRI) ||
                    (cfg.osc_select_cfg == sdr_pkg::OSC_SEL_PRI_PLL); // R2
  assign use_pll  = (cfg.osc_select_cfg == sdr_pkg::OSC_SEL_FRC_PLL) ||
                    (cfg.osc_select_cfg == sdr_pkg::OSC_SEL_PRI_PLL); // R2
  assign use_xtal = use_pri &&
                    (cfg.primary_osc_mode_cfg != sdr_pkg::PRI_MODE_OFF) &&
                    (cfg.primary_osc_mode_cfg != sdr_pkg::PRI_MODE_EC);
  assign ost_done  = ost_cnt_reg == '0;
  assign clk_ready = ost_done && (!pll_in_use || lock_s2_reg); // R3 R4
  assign dly_done  = dly_cnt_reg == '0;

  // sleep and idle inputs are deliberately not gating the dip path
  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= sdr_pkg::ST_PULSE;
    else if (dip_s2_reg)
      state_reg <= sdr_pkg::ST_PULSE; // R1 R8
    else
      unique case (state_reg)
        sdr_pkg::ST_IDLE:  state_reg <= sdr_pkg::ST_RUN;
        sdr_pkg::ST_PULSE:
          if (pulse_cnt_reg == '0)
            state_reg <= sdr_pkg::ST_WAIT;
        sdr_pkg::ST_WAIT:
          if (dly_done && clk_ready)
            state_reg <= sdr_pkg::ST_RUN; // R9
        sdr_pkg::ST_RUN:   state_reg <= sdr_pkg::ST_RUN;
        default:           state_reg <= sdr_pkg::ST_PULSE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || dip_s2_reg)
      pulse_cnt_reg <= sdr_pkg::CNT_W'(sdr_pkg::RESET_PULSE_CYC - 1);
    else if (state_reg == sdr_pkg::ST_PULSE && pulse_cnt_reg != '0)
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
  end

  // clock source latched as the pulse ends so a late cfg change is ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_source   <= sdr_pkg::OSC_SEL_FRC;
      pll_in_use   <= 1'b0;
      osc_mode_reg <= 1'b0;
    end
    else if (state_reg == sdr_pkg::ST_PULSE)
    begin
      clk_source   <= cfg.osc_select_cfg; // R2
      pll_in_use   <= use_pll; // R2
      osc_mode_reg <= use_xtal; // R3
    end
  end

  // start-up timer counts oscillator ticks, which arrive as enable pulses
  always_ff @(posedge clk)
  begin
    if (rst || state_reg == sdr_pkg::ST_PULSE)
      ost_cnt_reg <= sdr_pkg::CNT_W'(sdr_pkg::OSC_STARTUP_CYC);
    else if (!osc_mode_reg)
      ost_cnt_reg <= '0;
    else if (osc_tick && ost_cnt_reg != '0)
      ost_cnt_reg <= ost_cnt_reg - 1'b1; // R3
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_reg == sdr_pkg::ST_PULSE)
    begin
      if (!cfg.powerup_timer_zero)
        dly_cnt_reg <= sdr_pkg::CNT_W'(sdr_pkg::POWERUP_DELAY_CYC); // R5
      else if (use_xtal)
        dly_cnt_reg <= sdr_pkg::CNT_W'(sdr_pkg::FAILSAFE_DELAY_CYC); // R6
      else
        dly_cnt_reg <= '0;
    end
    else if (dly_cnt_reg != '0)
      dly_cnt_reg <= dly_cnt_reg - 1'b1; // R5
  end

  // a dip never clears the flag; set wins over a software clear
  always_ff @(posedge clk)
  begin
    if (rst)
      reset_control_reg <= sdr_pkg::RST_CTRL_RESET_VAL;
    else if (dip_s2_reg)
      reset_control_reg[sdr_pkg::RST_CTRL_DIP_BIT] <= 1'b1; // R7 R10
    else if (flag_clear)
      reset_control_reg[sdr_pkg::RST_CTRL_DIP_BIT] <= 1'b0; // R10
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      device_reset_pulse <= 1'b1;
      internal_reset     <= 1'b1;
      sysclk_enable      <= 1'b0;
    end
    else
    begin
      device_reset_pulse <= dip_s2_reg ||
        (state_reg == sdr_pkg::ST_PULSE && pulse_cnt_reg != '0); // R1
      // a dip re-asserts reset at once, even from the run state
      internal_reset     <= dip_s2_reg ||
        ((state_reg != sdr_pkg::ST_RUN) &&
        !(state_reg == sdr_pkg::ST_WAIT && dly_done && clk_ready)); // R1 R9
      sysclk_enable      <= (state_reg == sdr_pkg::ST_WAIT ||
        state_reg == sdr_pkg::ST_RUN) && clk_ready && !dip_s2_reg; // R3 R4
    end
  end

  // checks ride on the sequencer state, low-power inputs only qualify them
  chk_flag_sets: assert property (@(posedge clk) disable iff (rst) // R7
    dip_s2_reg |=> reset_control_reg[sdr_pkg::RST_CTRL_DIP_BIT])
    else $error("dip flag not set");
  chk_flag_holds: assert property (@(posedge clk) disable iff (rst) // R10
    reset_control_reg[sdr_pkg::RST_CTRL_DIP_BIT] && !flag_clear |=>
    reset_control_reg[sdr_pkg::RST_CTRL_DIP_BIT])
    else $error("dip flag lost");
  chk_pulse_on_dip: assert property (@(posedge clk) disable iff (rst) // R1
    dip_s2_reg |=> device_reset_pulse && internal_reset)
    else $error("no reset pulse on dip");
  chk_pulse_ends: assert property (@(posedge clk) disable iff (rst) // R1
    state_reg == sdr_pkg::ST_WAIT |-> !device_reset_pulse)
    else $error("reset pulse outlasts its count");
  chk_dip_in_sleep: assert property (@(posedge clk) disable iff (rst) // R8
    dip_s2_reg && (sleep_mode || idle_mode) |=> internal_reset)
    else $error("dip ignored in low power");
  chk_release_ready: assert property (@(posedge clk) disable iff (rst) // R9
    $fell(internal_reset) |-> $past(dly_done) && $past(clk_ready))
    else $error("early release");
  chk_run_released: assert property (@(posedge clk) disable iff (rst) // R9
    state_reg == sdr_pkg::ST_RUN |-> !internal_reset)
    else $error("reset still held in run");
  chk_clk_gated: assert property (@(posedge clk) disable iff (rst) // R3
    !$past(ost_done) |-> !sysclk_enable)
    else $error("clock before start-up timer");
  chk_pll_hold: assert property (@(posedge clk) disable iff (rst) // R4
    pll_in_use && !$past(lock_s2_reg) |-> !sysclk_enable)
    else $error("clock before pll lock");
  chk_delay_held: assert property (@(posedge clk) disable iff (rst) // R5
    state_reg == sdr_pkg::ST_WAIT && !dly_done |=> internal_reset)
    else $error("reset released during delay");
  chk_src_latch: assert property (@(posedge clk) disable iff (rst) // R2
    state_reg == sdr_pkg::ST_PULSE |=>
    clk_source == $past(cfg.osc_select_cfg))
    else $error("clock source not taken");
  chk_failsafe: assert property (@(posedge clk) disable iff (rst) // R6
    state_reg == sdr_pkg::ST_PULSE && cfg.powerup_timer_zero && use_xtal |=>
    dly_cnt_reg == sdr_pkg::CNT_W'(sdr_pkg::FAILSAFE_DELAY_CYC) ||
    state_reg == sdr_pkg::ST_PULSE)
    else $error("fail-safe delay not loaded");

  cov_release: cover property (@(posedge clk) disable iff (rst)
    $fell(internal_reset));
  cov_pll: cover property (@(posedge clk) disable iff (rst)
    pll_in_use && $rose(sysclk_enable));
  cov_clear: cover property (@(posedge clk) disable iff (rst)
    $fell(reset_control_reg[sdr_pkg::RST_CTRL_DIP_BIT]));
  cov_failsafe: cover property (@(posedge clk) disable iff (rst)
    state_reg == sdr_pkg::ST_PULSE && cfg.powerup_timer_zero && use_xtal);
  cov_sleep_dip: cover property (@(posedge clk) disable iff (rst)
    sleep_mode && dip_s2_reg);
endmodule

// >>> verification/sdr_testbench.sv
`timescale 1ns/1ns
module testbench;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              dip = 1'b0;
  logic              slp = 1'b0;
  logic              idl = 1'b0;
  sdr_pkg::sdr_cfg_t cfg = '0;
  logic              tick = 1'b0;
  logic [15:0]       octl = 16'h0000;
  logic              fclr = 1'b0;
  logic              pulse;
  logic              irst;
  logic              sclk;
  logic [2:0]        src;
  logic              pll;
  logic [15:0]       rctl;
  int                mismatches = 0;
  int                compares = 0;

  sdr_sequencer uut (
    .clk                (clk),
    .rst                (rst),
    .supply_dip_reset   (dip),
    .sleep_mode         (slp),
    .idle_mode          (idl),
    .cfg                (cfg),
    .osc_tick           (tick),
    .osc_control_reg    (octl),
    .flag_clear         (fclr),
    .device_reset_pulse (pulse),
    .internal_reset     (irst),
    .sysclk_enable      (sclk),
    .clk_source         (src),
    .pll_in_use         (pll),
    .reset_control_reg  (rctl)
  );

  always #10 clk = ~clk;
  // half-rate tick so the start-up timer must count ticks, not clocks
  always @(negedge clk) tick <= ~tick;

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (e !== g)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // release time is only known to within the sync and pulse slack
  task automatic chk_rng(input string nm, input int e, input int g);
    compares++;
    if (g < e - 12 || g > e + 12)
    begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic run(input logic [2:0] s, input logic [1:0] m, input logic z);
    int n, lk, dly, hold, e;
    logic p, x;
    p = (s == sdr_pkg::OSC_SEL_FRC_PLL) || (s == sdr_pkg::OSC_SEL_PRI_PLL);
    x = (s == sdr_pkg::OSC_SEL_PRI || s == sdr_pkg::OSC_SEL_PRI_PLL)
        && m != sdr_pkg::PRI_MODE_OFF && m != sdr_pkg::PRI_MODE_EC;
    lk = 60 + $urandom_range(2400);
    @(negedge clk);
    cfg = '{s, m, z};
    octl = 16'($urandom) & 16'hFFDF;
    slp = 1'($urandom);
    idl = 1'($urandom);
    dip = 1'b1;
    repeat (3) @(negedge clk);
    chk("pulse", 16'h1, {15'h0, pulse});
    chk("flag", 16'h2, rctl);
    dip = 1'b0;
    n = 0;
    while (pulse !== 1'b0 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (irst !== 1'b0 && n < 6000)
    begin
      @(negedge clk);
      n++;
      if (n == lk - 1 && p)
        chk("sysclk_held", 16'h0, {15'h0, sclk});
      if (n == lk)
        octl[sdr_pkg::OSC_CTRL_LOCK_BIT] = 1'b1;
    end
    dly = z ? (x ? sdr_pkg::FAILSAFE_DELAY_CYC : 0)
            : sdr_pkg::POWERUP_DELAY_CYC;
    hold = x ? 2 * sdr_pkg::OSC_STARTUP_CYC : 0;
    if (p && lk > hold)
      hold = lk;
    e = (dly > hold) ? dly : hold;
    chk_rng("release", e, n);
    chk("sysclk", 16'h1, {15'h0, sclk});
    chk("source", {13'h0, s}, {13'h0, src});
    chk("pll", {15'h0, p}, {15'h0, pll});
    chk("flag_kept", 16'h2, rctl);
  endtask

  initial
  begin
    void'($urandom(32'h10A736A2));
    repeat (12) @(negedge clk);
    chk("rst_flag", sdr_pkg::RST_CTRL_RESET_VAL, rctl);
    chk("rst_hold", 16'h1, {15'h0, irst & ~sclk});
    rst = 1'b0;
    repeat (4000) @(negedge clk);
    chk("no_flag", 16'h0, rctl);
    run(3'h0, 2'h3, 1'b0);
    run(3'h1, 2'h3, 1'b0);
    run(3'h2, 2'h1, 1'b1);
    run(3'h3, 2'h2, 1'b0);
    run(3'h2, 2'h0, 1'b1);
    run(3'($urandom_range(3)), 2'($urandom), 1'b1);
    @(negedge clk);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    @(negedge clk);
    chk("flag_clr", 16'h0, rctl);
    close_out();
  end

  initial
  begin
    #1_800_000;
    mismatches++;
    close_out();
  end
endmodule
